/* File: core/spis_pkg.sv */
// Purpose: Shared constants and types for the serial port interrupt status block
// Assumes: 32-bit register port, word offsets as byte addresses
// Notes: Bit positions are common to raw, mask, masked and clear registers
package spis_pkg;

  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;
  localparam int NSRC = 7;

  localparam logic [ADDR_W-1:0] OFF_MASK = 12'h038;
  localparam logic [ADDR_W-1:0] OFF_RAW = 12'h03C;
  localparam logic [ADDR_W-1:0] OFF_MASKED = 12'h040;
  localparam logic [ADDR_W-1:0] OFF_CLEAR = 12'h044;

  localparam int SRC_LSB = 4;
  localparam int BIT_RX = 4;
  localparam int BIT_TX = 5;
  localparam int BIT_RXTO = 6;
  localparam int BIT_FRAMING = 7;
  localparam int BIT_PARITY = 8;
  localparam int BIT_BREAK = 9;
  localparam int BIT_OVERRUN = 10;

  localparam logic [3:0] RAW_LOW_RSVD = 4'hF;
  localparam logic [NSRC-1:0] SRC_RESET = 7'h00;
  localparam logic [DATA_W-1:0] DATA_ZERO = 32'h0000_0000;

  // Source vector, one bit per condition, bit 0 is receive
  typedef struct packed {
    logic overrun;
    logic brk;
    logic parity;
    logic framing;
    logic rx_timeout;
    logic tx;
    logic rx;
  } spis_src_t;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic wr;
    logic rd;
  } spis_req_t;

endpackage : spis_pkg

/* File: core/spis_src_bit.sv */
// Purpose: One sticky interrupt source with its mask gate
// Assumes: Event pulses come from logic on the same clock
// Notes: A set in the clearing cycle wins over the clear
`timescale 1ns/10ps
`default_nettype none
module spis_src_bit (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic rst_i,
  // Event and control
  input wire logic event_i,
  input wire logic clear_i,
  input wire logic mask_i,
  // Status
  output logic raw_o,
  output logic masked_o
);
  logic raw_reg;
  logic raw_next;

  always_comb begin
    raw_next = raw_reg;
    if (clear_i) begin
      raw_next = 1'b0;
    end
    // Set beats clear so an event is never lost
    if (event_i) begin
      raw_next = 1'b1;
    end
  end

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      raw_reg <= 1'b0;
    end else begin
      raw_reg <= raw_next;
    end
  end

  assign raw_o = raw_reg;
  assign masked_o = raw_reg & mask_i;
endmodule : spis_src_bit
`default_nettype wire

/* File: core/spis_top.sv */
// Purpose: Raw and masked interrupt status for a serial port, with mask and clear
// Assumes: Event pulses from receiver and transmitter on mclk_i
// Notes: Read data valid the cycle after the read strobe only
// Functional notes
// - Raw bits show state, mask ignored
// - Transmit raw state at bit five
// - Masked read returns raw gated by mask
// - Masked status writes change nothing
// - Masked status at 0x040, bits 10..4
// - Source forwarded only when mask one
// - Raw status at 0x03C, same bits
// - Write one clears raw and masked
//
// The address-and-strobe port was decided locally.
`timescale 1ns/10ps
`default_nettype none
module spis_top #(
  parameter int NSRC_P = 7
) (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic rst_i,
  // Condition events from the serial port, one-cycle pulses
  input wire spis_pkg::spis_src_t event_i,
  // Register port
  input wire logic [spis_pkg::ADDR_W-1:0] addr_i,
  input wire logic [spis_pkg::DATA_W-1:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [spis_pkg::DATA_W-1:0] rdata_o,
  // Interrupt request
  output logic irq_o,
  output spis_pkg::spis_src_t masked_o
);
  import spis_pkg::*;

  // Layout checks: the packing below serves only these shapes
  if (NSRC_P != NSRC) begin : g_chk_nsrc
    $error("spis_top: NSRC_P must match the register layout");
  end
  if ($bits(spis_src_t) != NSRC) begin : g_chk_width
    $error("spis_top: source struct width differs from NSRC");
  end
  if (SRC_LSB + NSRC > DATA_W) begin : g_chk_fit
    $error("spis_top: source field runs past the data word");
  end
  if ($bits(RAW_LOW_RSVD) != SRC_LSB) begin : g_chk_low
    $error("spis_top: reserved low field must fill the bits below the sources");
  end
  if (BIT_RX < SRC_LSB || BIT_RX >= SRC_LSB + NSRC) begin : g_chk_rx
    $error("spis_top: receive bit outside the source field");
  end
  if (BIT_TX < SRC_LSB || BIT_TX >= SRC_LSB + NSRC) begin : g_chk_tx
    $error("spis_top: transmit bit outside the source field");
  end
  if (BIT_RXTO < SRC_LSB || BIT_RXTO >= SRC_LSB + NSRC) begin : g_chk_rxto
    $error("spis_top: receive timeout bit outside the source field");
  end
  if (BIT_FRAMING < SRC_LSB || BIT_FRAMING >= SRC_LSB + NSRC) begin : g_chk_framing
    $error("spis_top: framing bit outside the source field");
  end
  if (BIT_PARITY < SRC_LSB || BIT_PARITY >= SRC_LSB + NSRC) begin : g_chk_parity
    $error("spis_top: parity bit outside the source field");
  end
  if (BIT_BREAK < SRC_LSB || BIT_BREAK >= SRC_LSB + NSRC) begin : g_chk_break
    $error("spis_top: break bit outside the source field");
  end
  if (BIT_OVERRUN < SRC_LSB || BIT_OVERRUN >= SRC_LSB + NSRC) begin : g_chk_overrun
    $error("spis_top: overrun bit outside the source field");
  end
  // Two sources on one bit would hide a condition
  localparam int SRC_SPAN = (1 << (BIT_RX - SRC_LSB)) | (1 << (BIT_TX - SRC_LSB)) |
    (1 << (BIT_RXTO - SRC_LSB)) | (1 << (BIT_FRAMING - SRC_LSB)) |
    (1 << (BIT_PARITY - SRC_LSB)) | (1 << (BIT_BREAK - SRC_LSB)) |
    (1 << (BIT_OVERRUN - SRC_LSB));
  if (SRC_SPAN != (1 << NSRC) - 1) begin : g_chk_unique
    $error("spis_top: two sources share a register bit");
  end
  if (OFF_MASK == OFF_RAW || OFF_MASK == OFF_MASKED || OFF_MASK == OFF_CLEAR ||
      OFF_RAW == OFF_MASKED || OFF_RAW == OFF_CLEAR || OFF_MASKED == OFF_CLEAR) begin : g_chk_offs
    $error("spis_top: two register words share an offset");
  end

  spis_req_t req;
  spis_src_t clr_src;
  spis_src_t raw_src;
  spis_src_t msk_src;
  spis_src_t mask_reg;
  spis_src_t mask_next;
  logic hit_mask;
  logic hit_raw;
  logic hit_masked;
  logic hit_clear;
  logic wr_mask;
  logic wr_clear;
  logic [DATA_W-1:0] mask_word;
  logic [DATA_W-1:0] raw_word;
  logic [DATA_W-1:0] masked_word;
  logic [DATA_W-1:0] rdata_reg;
  logic [DATA_W-1:0] rdata_next;

  // Places each source at its own register bit; other bits read zero, but raw bits 3..0 read ones
  function automatic logic [DATA_W-1:0] place_src(input spis_src_t src);
    logic [DATA_W-1:0] word;
    word = DATA_ZERO;
    word[BIT_RX] = src.rx;
    word[BIT_TX] = src.tx;
    word[BIT_RXTO] = src.rx_timeout;
    word[BIT_FRAMING] = src.framing;
    word[BIT_PARITY] = src.parity;
    word[BIT_BREAK] = src.brk;
    word[BIT_OVERRUN] = src.overrun;
    return word;
  endfunction : place_src

  // Mask and clear writes use the same bit positions as the status words
  function automatic spis_src_t pick_src(input logic [DATA_W-1:0] word);
    spis_src_t src;
    src.rx = word[BIT_RX];
    src.tx = word[BIT_TX];
    src.rx_timeout = word[BIT_RXTO];
    src.framing = word[BIT_FRAMING];
    src.parity = word[BIT_PARITY];
    src.brk = word[BIT_BREAK];
    src.overrun = word[BIT_OVERRUN];
    return src;
  endfunction : pick_src

  assign req = '{addr: addr_i, wdata: wdata_i, wr: wr_i, rd: rd_i};

  // One hit per mapped word; unmapped addresses hit nothing
  always_comb begin
    hit_mask = 1'b0;
    hit_raw = 1'b0;
    hit_masked = 1'b0;
    hit_clear = 1'b0;
    case (req.addr)
      OFF_MASK: begin
        hit_mask = 1'b1;
      end
      OFF_RAW: begin
        hit_raw = 1'b1;
      end
      OFF_MASKED: begin
        hit_masked = 1'b1;
      end
      OFF_CLEAR: begin
        hit_clear = 1'b1;
      end
      default: begin
        hit_mask = 1'b0;
      end
    endcase
  end

  // status words take no writes
  // Only mask and clear decode a write, so raw and masked writes fall away
  assign wr_mask = req.wr & hit_mask;
  assign wr_clear = req.wr & hit_clear;

  always_comb begin
    clr_src = SRC_RESET;
    if (wr_clear) begin
      clr_src = pick_src(req.wdata);
    end
  end

  always_comb begin
    mask_next = mask_reg;
    if (wr_mask) begin
      mask_next = pick_src(req.wdata);
    end
  end

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      mask_reg <= SRC_RESET;
    end else begin
      mask_reg <= mask_next;
    end
  end

  // One sticky bit per source; instance names follow the struct fields
  spis_src_bit u_rx (
    .mclk_i(mclk_i),
    .rst_i(rst_i),
    .event_i(event_i.rx),
    .clear_i(clr_src.rx),
    .mask_i(mask_reg.rx),
    .raw_o(raw_src.rx),
    .masked_o(msk_src.rx)
  );

  spis_src_bit u_tx (
    .mclk_i(mclk_i),
    .rst_i(rst_i),
    .event_i(event_i.tx),
    .clear_i(clr_src.tx),
    .mask_i(mask_reg.tx),
    .raw_o(raw_src.tx),
    .masked_o(msk_src.tx)
  );

  spis_src_bit u_rx_timeout (
    .mclk_i(mclk_i),
    .rst_i(rst_i),
    .event_i(event_i.rx_timeout),
    .clear_i(clr_src.rx_timeout),
    .mask_i(mask_reg.rx_timeout),
    .raw_o(raw_src.rx_timeout),
    .masked_o(msk_src.rx_timeout)
  );

  spis_src_bit u_framing (
    .mclk_i(mclk_i),
    .rst_i(rst_i),
    .event_i(event_i.framing),
    .clear_i(clr_src.framing),
    .mask_i(mask_reg.framing),
    .raw_o(raw_src.framing),
    .masked_o(msk_src.framing)
  );

  spis_src_bit u_parity (
    .mclk_i(mclk_i),
    .rst_i(rst_i),
    .event_i(event_i.parity),
    .clear_i(clr_src.parity),
    .mask_i(mask_reg.parity),
    .raw_o(raw_src.parity),
    .masked_o(msk_src.parity)
  );

  spis_src_bit u_brk (
    .mclk_i(mclk_i),
    .rst_i(rst_i),
    .event_i(event_i.brk),
    .clear_i(clr_src.brk),
    .mask_i(mask_reg.brk),
    .raw_o(raw_src.brk),
    .masked_o(msk_src.brk)
  );

  spis_src_bit u_overrun (
    .mclk_i(mclk_i),
    .rst_i(rst_i),
    .event_i(event_i.overrun),
    .clear_i(clr_src.overrun),
    .mask_i(mask_reg.overrun),
    .raw_o(raw_src.overrun),
    .masked_o(msk_src.overrun)
  );

  always_comb begin
    mask_word = place_src(mask_reg);
    raw_word = place_src(raw_src);
    raw_word[SRC_LSB-1:0] = RAW_LOW_RSVD;
    masked_word = place_src(msk_src);
  end

  // Clear word and unmapped addresses read zero
  always_comb begin
    rdata_next = DATA_ZERO;
    if (req.rd) begin
      if (hit_mask) begin
        rdata_next = mask_word;
      end
      if (hit_raw) begin
        rdata_next = raw_word;
      end
      if (hit_masked) begin
        rdata_next = masked_word;
      end
    end
  end

  // Data stands for one cycle only; a late reader sees zero, not a stale word
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      rdata_reg <= DATA_ZERO;
    end else begin
      rdata_reg <= rdata_next;
    end
  end

  assign rdata_o = rdata_reg;
  // OR of masked
  // Combinational so the request tracks status with no extra lag
  assign irq_o = |msk_src;
  assign masked_o = msk_src;

endmodule : spis_top
`default_nettype wire

/* File: tb/serial_port_irq_status_test.sv */
// Purpose: Random check of spis_top against a model
// Assumes: Read data one cycle after strobe
// Notes: Sparse events keep clears visible
`timescale 1ns/10ps
`default_nettype none
module serial_port_irq_status_test;
  import spis_pkg::*;
  logic mclk_i = 0, rst_i = 1, wr_i = 0, rd_i = 0, irq_o;
  spis_src_t event_i = '0, masked_o;
  logic [ADDR_W-1:0] addr_i = '0, offs [4] = '{OFF_MASK, OFF_RAW, OFF_MASKED, OFF_CLEAR};
  logic [DATA_W-1:0] wdata_i = '0, rdata_o, op;
  int seed = 13, num_errors = 0, cmp_count = 0, raw = 0, msk = 0, exp_q [$];
  spis_top i_spis_top (.mclk_i(mclk_i), .rst_i(rst_i), .event_i(event_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .irq_o(irq_o), .masked_o(masked_o));
  always #20 mclk_i = ~mclk_i;
  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("[ERR] %s exp %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task test_done;
    $display("checks %0d errors %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : test_done
  initial begin
    repeat (5) @(posedge mclk_i);
    rst_i <= 0;
    for (int i = 0; i < 4000; i++) begin
      @(posedge mclk_i);
      // Model takes the request held over this edge; set beats clear
      if (!rst_i) begin
        if (rd_i) exp_q.push_back(addr_i == OFF_MASK ? msk << SRC_LSB : addr_i == OFF_RAW ?
          raw << SRC_LSB | RAW_LOW_RSVD : addr_i == OFF_MASKED ? (raw & msk) << SRC_LSB : 0);
        if (wr_i && addr_i == OFF_MASK) msk = wdata_i[SRC_LSB +: NSRC];
        if (wr_i && addr_i == OFF_CLEAR) raw &= ~wdata_i[SRC_LSB +: NSRC];
        raw |= event_i;
      end
      // Second reset in mid-run wipes status, mask and read data at once
      rst_i <= (i == 2000 || i == 2001);
      if (i == 2000) begin
        raw = 0;
        msk = 0;
        exp_q.delete();
      end
      op = $random(seed);
      event_i <= op[3:0] == 0 ? op[10:4] : '0;
      wr_i <= op[13:12] == 1;
      rd_i <= op[13:12] == 2;
      addr_i <= op[17] ? 12'h048 : offs[op[15:14]];
      wdata_i <= $random(seed);
      @(negedge mclk_i);
      chk("masked", masked_o, raw & msk);
      chk("irq", irq_o, |(raw & msk));
      chk("rdata", rdata_o, exp_q.size() ? exp_q.pop_front() : 0);
    end
    test_done();
  end
endmodule : serial_port_irq_status_test
bind spis_top spis_chk i_spis_chk (.mclk_i(mclk_i), .rst_i(rst_i), .event_i(event_i), .addr_i(addr_i),
  .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .irq_o(irq_o), .masked_o(masked_o));
`default_nettype wire

/* File: tb/spis_chk.sv */
// Purpose: Port checks for spis_top
// Assumes: One clock
// Notes: Bound from the test top
`timescale 1ns/10ps
`default_nettype none
module spis_chk (
  // Watched ports
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire spis_pkg::spis_src_t event_i,
  input wire logic [spis_pkg::ADDR_W-1:0] addr_i,
  input wire logic [spis_pkg::DATA_W-1:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [spis_pkg::DATA_W-1:0] rdata_o,
  input wire logic irq_o,
  input wire spis_pkg::spis_src_t masked_o
);
  import spis_pkg::*;
  default clocking @(posedge mclk_i); endclocking
  default disable iff (rst_i);
  sequence s_tx_rd;
    event_i.tx ##1 (rd_i && addr_i == OFF_RAW);
  endsequence
  property p_irq; irq_o == (|masked_o); endproperty
  property p_irq_rd; rd_i && addr_i == OFF_MASKED |=> (|rdata_o[10:4]) == $past(irq_o); endproperty
  property p_tx; s_tx_rd |=> rdata_o[BIT_TX]; endproperty
  property p_low; rd_i && addr_i == OFF_RAW |=> rdata_o[3:0] == RAW_LOW_RSVD; endproperty
  property p_rsv; rd_i && addr_i == OFF_MASKED |=> rdata_o[31:11] == 0 && rdata_o[3:0] == 0; endproperty
  property p_mrd; rd_i && addr_i == OFF_MASKED |=> rdata_o[10:4] == $past(masked_o); endproperty
  property p_wm; wr_i && addr_i == OFF_MASKED && event_i == 0 |=> $stable(masked_o); endproperty
  property p_clr; wr_i && addr_i == OFF_CLEAR && event_i == 0 |=> ({masked_o, 4'h0} & $past(wdata_i)) == 0; endproperty
  property p_idle; !wr_i && event_i == 0 |=> $stable(masked_o); endproperty
  a_irq: assert property (p_irq) else $error("irq");
  a_irq_rd: assert property (p_irq_rd) else $error("irq vs masked rd");
  a_tx: assert property (p_tx) else $error("tx raw");
  a_low: assert property (p_low) else $error("raw low");
  a_rsv: assert property (p_rsv) else $error("rsvd");
  a_mrd: assert property (p_mrd) else $error("masked rd");
  a_wm: assert property (p_wm) else $error("masked wr");
  a_clr: assert property (p_clr) else $error("clear");
  a_idle: assert property (p_idle) else $error("idle");
endmodule : spis_chk
`default_nettype wire
